// ===== sfpe_pkg.sv
/*
  Constants, opcodes and states for the serial flash program/erase sequencer.
  Assumes a single 100 MHz core clock that samples the serial link pins.
*/
package sfpe_pkg;
  localparam logic [7:0] OP_UNLOCK    = 8'h06;
  localparam logic [7:0] OP_PW3       = 8'h02;
  localparam logic [7:0] OP_PW4       = 8'h12;
  localparam logic [7:0] OP_QPW3      = 8'h32;
  localparam logic [7:0] OP_QPW4      = 8'h34;
  localparam logic [7:0] OP_EQPW3     = 8'hC2;
  localparam logic [7:0] OP_EQPW4     = 8'h3E;
  localparam logic [7:0] OP_SC3       = 8'h20;
  localparam logic [7:0] OP_SC4       = 8'h21;
  localparam int         PAGE_BYTES   = 256;
  localparam int         CLK_MHZ      = 100;
  localparam int         T_PP_US      = 1000;
  localparam int         T_SC_US      = 50000;
  localparam int         PP_CYCLES    = T_PP_US * CLK_MHZ;
  localparam int         SC_CYCLES    = T_SC_US * CLK_MHZ;
  localparam logic [1:0] ADDR_BYTES3  = 2'h3;
  localparam logic [1:0] ADDR_BYTES4  = 2'h0;

  typedef enum logic [2:0] {
    SFPE_IDLE   = 3'b000,
    SFPE_OPCODE = 3'b001,
    SFPE_ADDR   = 3'b010,
    SFPE_DATA   = 3'b011,
    SFPE_SINK   = 3'b100
  } sfpe_state_t;
endpackage

// ===== sfpe_core.sv
/*
  Program/erase command sequencer of a serial NOR flash device.
  Assumes the host drives select, clock and data; pins are asynchronous to i_clk
  and the link clock is slow enough (80 ns period) for edge detection by sampling.
  The memory array lives outside: this block issues byte-write and sector-clear
  strobes to it.
*/
`timescale 1ns/1ps
module sfpe_core #(
  parameter int PP_CYCLES   = sfpe_pkg::PP_CYCLES,
  parameter int SC_CYCLES   = sfpe_pkg::SC_CYCLES,
  parameter int SECTOR_BITS = 12
) (
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_reset,
  // Serial link pins
  input  wire logic        i_sel_n,
  input  wire logic        i_sclk,
  input  wire logic [3:0]  i_quad_io_lines,
  // Configuration
  input  wire logic        i_four_byte_mode,
  input  wire logic [4:0]  i_protect_level_bits,
  input  wire logic        i_protect_hit,
  // Protection query
  output logic [31:0]      o_query_addr,
  // Status
  output logic             o_busy_flag,
  output logic             o_write_latch_flag,
  // Array side
  output logic             o_array_wr,
  output logic [31:0]      o_array_addr,
  output logic [7:0]       o_array_data,
  output logic             o_array_sector_clear
);
  // The page buffer drains inside the busy time, so that time must cover a whole page.
  if (PP_CYCLES < sfpe_pkg::PAGE_BYTES || SC_CYCLES < 1 || SECTOR_BITS < 8 || SECTOR_BITS > 31)
  begin
    $error("sfpe_core: bad parameters");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Three-stage pin sampling; a change counts when stages two and three agree.
  logic [2:0] cs_sync_reg;
  logic [2:0] ck_sync_reg;
  logic [3:0] io_s1_reg;
  logic [3:0] io_s2_reg;
  logic [3:0] io_s3_reg;
  logic       cs_n_reg;
  logic       ck_reg;
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      cs_sync_reg <= 3'h7;
      ck_sync_reg <= 3'h0;
      io_s1_reg   <= 4'h0;
      io_s2_reg   <= 4'h0;
      io_s3_reg   <= 4'h0;
      cs_n_reg    <= 1'b1;
      ck_reg      <= 1'b0;
    end
    else
    begin
      cs_sync_reg <= {cs_sync_reg[1:0], i_sel_n};
      ck_sync_reg <= {ck_sync_reg[1:0], i_sclk};
      io_s1_reg   <= i_quad_io_lines;
      io_s2_reg   <= io_s1_reg;
      io_s3_reg   <= io_s2_reg;
      if (cs_sync_reg[1] == cs_sync_reg[2])
        cs_n_reg <= cs_sync_reg[2];
      if (ck_sync_reg[1] == ck_sync_reg[2])
        ck_reg <= ck_sync_reg[2];
    end
  end

  logic ck_new;
  logic ck_rise;
  logic cs_new;
  logic cs_rise;
  logic cs_fall;
  assign ck_new  = (ck_sync_reg[1] == ck_sync_reg[2]) ? ck_sync_reg[2] : ck_reg;
  assign cs_new  = (cs_sync_reg[1] == cs_sync_reg[2]) ? cs_sync_reg[2] : cs_n_reg;
  assign ck_rise = ck_new & ~ck_reg & ~cs_n_reg;
  assign cs_rise = cs_new & ~cs_n_reg;
  assign cs_fall = ~cs_new & cs_n_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Bit shifter: one bit per clock on single line, a nibble on four lines.
  logic        quad_reg;
  logic [7:0]  shift_reg;
  logic [3:0]  bits_reg;
  logic [7:0]  shift_next;
  logic [3:0]  bits_next;
  logic        byte_done;
  always_comb
  begin
    shift_next = quad_reg ? {shift_reg[3:0], io_s3_reg} : {shift_reg[6:0], io_s3_reg[0]};
    bits_next  = quad_reg ? bits_reg + 4'h4 : bits_reg + 4'h1;
  end
  assign byte_done = ck_rise && (bits_next == 4'h8);

  always_ff @(posedge i_clk)
  begin
    if (i_reset || cs_fall)
    begin
      shift_reg <= 8'h00;
      bits_reg  <= 4'h0;
    end
    else if (ck_rise)
    begin
      shift_reg <= shift_next;
      bits_reg  <= byte_done ? 4'h0 : bits_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command decoder.
  function automatic logic is_program(input logic [7:0] op);
    is_program = (op == sfpe_pkg::OP_PW3)  || (op == sfpe_pkg::OP_PW4) ||
                 (op == sfpe_pkg::OP_QPW3) || (op == sfpe_pkg::OP_QPW4) ||
                 (op == sfpe_pkg::OP_EQPW3) || (op == sfpe_pkg::OP_EQPW4);
  endfunction

  function automatic logic is_quad_addr(input logic [7:0] op);
    is_quad_addr = (op == sfpe_pkg::OP_QPW3) || (op == sfpe_pkg::OP_QPW4) ||
                   (op == sfpe_pkg::OP_EQPW3) || (op == sfpe_pkg::OP_EQPW4);
  endfunction

  sfpe_pkg::sfpe_state_t state_reg;
  logic [7:0]  op_reg;
  logic [31:0] addr_reg;
  logic [1:0]  abytes_reg;
  logic [7:0]  offset_reg;
  logic        have_data_reg;
  logic        aligned_reg;
  logic        unlock_reg;

  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      state_reg     <= sfpe_pkg::SFPE_IDLE;
      op_reg        <= 8'h00;
      addr_reg      <= 32'h0000_0000;
      abytes_reg    <= sfpe_pkg::ADDR_BYTES3;
      offset_reg    <= 8'h00;
      have_data_reg <= 1'b0;
      aligned_reg   <= 1'b0;
      unlock_reg    <= 1'b0;
      quad_reg      <= 1'b0;
    end
    else if (cs_fall)
    begin
      state_reg     <= sfpe_pkg::SFPE_OPCODE;
      quad_reg      <= 1'b0;
      have_data_reg <= 1'b0;
      aligned_reg   <= 1'b0;
      unlock_reg    <= 1'b0;
      addr_reg      <= 32'h0000_0000;
    end
    else if (cs_rise)
      state_reg <= sfpe_pkg::SFPE_IDLE;
    else if (ck_rise)
    begin
      aligned_reg <= byte_done;
      case (state_reg)
        sfpe_pkg::SFPE_OPCODE:
          if (byte_done)
          begin
            op_reg     <= shift_next;
            unlock_reg <= (shift_next == sfpe_pkg::OP_UNLOCK);
            abytes_reg <= i_four_byte_mode ? sfpe_pkg::ADDR_BYTES4 : sfpe_pkg::ADDR_BYTES3;
            quad_reg   <= is_quad_addr(shift_next);
            state_reg  <= (is_program(shift_next) || shift_next == sfpe_pkg::OP_SC3 ||
                           shift_next == sfpe_pkg::OP_SC4 ) ? sfpe_pkg::SFPE_ADDR : sfpe_pkg::SFPE_SINK;
          end
        sfpe_pkg::SFPE_ADDR:
          if (byte_done)
          begin
            addr_reg   <= {addr_reg[23:0], shift_next};
            abytes_reg <= abytes_reg - 2'h1;
            if (abytes_reg == 2'h1)
            begin
              offset_reg <= shift_next;
              state_reg  <= is_program(op_reg) ? sfpe_pkg::SFPE_DATA : sfpe_pkg::SFPE_SINK;
            end
          end
        sfpe_pkg::SFPE_DATA:
          if (byte_done)
          begin
            have_data_reg <= 1'b1;
            offset_reg    <= offset_reg + 8'h01;
          end
        sfpe_pkg::SFPE_SINK:
        begin
          // Any clock after the last expected byte voids an unlock or an erase.
          unlock_reg  <= 1'b0;
          aligned_reg <= 1'b0;
        end
        default:
          state_reg <= sfpe_pkg::SFPE_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Page buffer: holds the bytes of this frame; later bytes overwrite earlier.
  localparam int PAGE_BYTES_L = sfpe_pkg::PAGE_BYTES;
  logic [7:0] page_mem [PAGE_BYTES_L-1:0];
  logic [PAGE_BYTES_L-1:0] valid_reg;
  // A frame sent during the self-timed cycle must not disturb the page being drained.
  always_ff @(posedge i_clk)
  begin
    if (state_reg == sfpe_pkg::SFPE_DATA && byte_done && !cs_fall && !cs_rise && !o_busy_flag)
      page_mem[offset_reg] <= shift_next;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Commit at select rise, then the self-timed cycle.
  logic        commit_pp;
  logic        commit_sc;
  logic [31:0] tmr_reg;
  logic        erase_reg;
  logic        drain_reg;
  logic [8:0]  drain_idx_reg;
  logic [23:0] drain_page_reg;
  logic [31:0] page_base;
  assign page_base    = {addr_reg[31:8], 8'h00};
  assign o_query_addr = addr_reg;
  // A program commits only on a byte boundary after at least one data byte.
  assign commit_pp = cs_rise && state_reg == sfpe_pkg::SFPE_DATA && have_data_reg &&
                     bits_reg == 4'h0 && o_write_latch_flag && !o_busy_flag && !i_protect_hit;
  assign commit_sc = cs_rise && state_reg == sfpe_pkg::SFPE_SINK && aligned_reg &&
                     !is_program(op_reg) && abytes_reg == 2'h0 &&
                     (op_reg == sfpe_pkg::OP_SC3 || op_reg == sfpe_pkg::OP_SC4) &&
                     o_write_latch_flag && !o_busy_flag && !i_protect_hit;

  always_ff @(posedge i_clk)
  begin
    if (i_reset)
      valid_reg <= '0;
    else if (cs_fall && !o_busy_flag)
      valid_reg <= '0;
    else if (state_reg == sfpe_pkg::SFPE_DATA && byte_done && !cs_rise && !o_busy_flag)
      valid_reg[offset_reg] <= 1'b1;
    else if (drain_reg)
      valid_reg[drain_idx_reg[7:0]] <= 1'b0;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      o_busy_flag          <= 1'b0;
      o_write_latch_flag   <= 1'b0;
      tmr_reg              <= 32'h0000_0000;
      erase_reg            <= 1'b0;
      drain_reg            <= 1'b0;
      drain_idx_reg        <= 9'h000;
      drain_page_reg       <= 24'h00_0000;
      o_array_wr           <= 1'b0;
      o_array_addr         <= 32'h0000_0000;
      o_array_data         <= 8'h00;
      o_array_sector_clear <= 1'b0;
    end
    else
    begin
      o_array_wr           <= 1'b0;
      o_array_sector_clear <= 1'b0;
      if (commit_pp || commit_sc)
      begin
        o_busy_flag        <= 1'b1;
        o_write_latch_flag <= 1'b0;
        erase_reg          <= commit_sc;
        drain_reg          <= commit_pp;
        drain_idx_reg      <= 9'h000;
        drain_page_reg     <= addr_reg[31:8];
        tmr_reg            <= commit_sc ? 32'(SC_CYCLES - 1) : 32'(PP_CYCLES - 1);
        o_array_sector_clear <= commit_sc;
        o_array_addr <= commit_sc ? (addr_reg & ~((32'h1 << SECTOR_BITS) - 32'h1)) : page_base;
      end
      else if (cs_rise && unlock_reg && aligned_reg && !o_busy_flag)
        o_write_latch_flag <= 1'b1;
      else if (o_busy_flag)
      begin
        if (drain_reg)
        begin
          o_array_wr    <= valid_reg[drain_idx_reg[7:0]];
          o_array_addr  <= {drain_page_reg, drain_idx_reg[7:0]};
          o_array_data  <= page_mem[drain_idx_reg[7:0]];
          drain_idx_reg <= drain_idx_reg + 9'h001;
          drain_reg     <= drain_idx_reg != 9'(PAGE_BYTES_L - 1);
        end
        if (tmr_reg == 32'h0000_0000)
          o_busy_flag <= 1'b0;
        else
          tmr_reg <= tmr_reg - 32'h0000_0001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  a_busy_on_commit: assert property (@(posedge i_clk) disable iff (i_reset)
    (commit_pp || commit_sc) |=> o_busy_flag && !o_write_latch_flag)
    else $error("busy not raised on commit");
  a_no_commit_unlatched: assert property (@(posedge i_clk) disable iff (i_reset)
    $rose(o_busy_flag) |-> $past(o_write_latch_flag) && !$past(i_protect_hit))
    else $error("cycle started without latch or under protection");
  a_pp_byte_aligned: assert property (@(posedge i_clk) disable iff (i_reset)
    cs_rise && bits_reg != 4'h0 |=> !$rose(o_busy_flag))
    else $error("cycle started off a byte boundary");
  a_latch_clear_busy: assert property (@(posedge i_clk) disable iff (i_reset)
    $rose(o_busy_flag) |-> !o_write_latch_flag)
    else $error("latch flag still set in cycle");
  a_busy_falls_done: assert property (@(posedge i_clk) disable iff (i_reset)
    $fell(o_busy_flag) |-> $past(tmr_reg) == 32'h0000_0000)
    else $error("busy ended early");
  a_sc_after_addr: assert property (@(posedge i_clk) disable iff (i_reset)
    commit_sc |=> o_array_sector_clear)
    else $error("sector clear not issued");
  a_wr_in_page: assert property (@(posedge i_clk) disable iff (i_reset)
    o_array_wr |-> o_array_addr[31:8] == $past(o_array_addr[31:8]))
    else $error("write left the page");
  a_wr_only_busy: assert property (@(posedge i_clk) disable iff (i_reset)
    o_array_wr |-> o_busy_flag)
    else $error("array write outside cycle");
endmodule

// ===== sfpe_host.sv
/*
  Behavioural host controller that drives select, link clock and data pins.
  Assumes one caller at a time, and that the core clock runs at 100 MHz.
*/
`timescale 1ns/1ps
module sfpe_host (
  // Clock
  input  wire logic  i_clk,
  // Serial link pins
  output logic       o_sel_n,
  output logic       o_sclk,
  output logic [3:0] o_io
);
  initial
  begin
    o_sel_n = 1'b1;
    o_sclk  = 1'b0;
    o_io    = 4'h0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] dat(input int k, input logic [7:0] seed);
    return (k < 256) ? (k[7:0] ^ seed) : 8'hA5;
  endfunction

  task automatic step(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask

  // Each link clock half lasts four core cycles, so the period is 80 ns.
  task automatic bit_out(input logic [3:0] v);
    o_io = v;
    step(4);
    o_sclk = 1'b1;
    step(4);
    o_sclk = 1'b0;
  endtask

  task automatic byte_out(input logic [7:0] b, input bit quad);
    if (quad)
    begin
      bit_out(b[7:4]);
      bit_out(b[3:0]);
    end
    else
      for (int j = 7; j >= 0; j--)
        bit_out({4{b[j]}});
  endtask

  // Extra bits break the byte boundary on purpose, for the abort cases.
  task automatic frame(input logic [7:0] op, input logic [31:0] addr, input int nab, input int nd,
                       input logic [7:0] seed, input bit quad, input int extra);
    o_sel_n = 1'b0;
    step(4);
    byte_out(op, 1'b0);
    for (int a = nab - 1; a >= 0; a--)
      byte_out(addr[8*a +: 8], quad);
    for (int k = 0; k < nd; k++)
      byte_out(dat(k, seed), quad);
    for (int e = 0; e < extra; e++)
      bit_out(4'hA);
    step(4);
    o_sel_n = 1'b1;
    o_io    = ~o_io;
    step(8);
  endtask
endmodule

// ===== sfpe_core_bench.sv
/*
  Self-checking bench of the program/erase sequencer, driven through the host model.
  Assumes shortened busy counts; the array is modelled by a log of write strobes.
*/
`timescale 1ns/1ps
module sfpe_core_bench;
  localparam int PP = 300;
  localparam int SC = 600;
  localparam logic [7:0] PROG_OPS [6] = '{sfpe_pkg::OP_PW3, sfpe_pkg::OP_PW4, sfpe_pkg::OP_QPW3,
                                         sfpe_pkg::OP_QPW4, sfpe_pkg::OP_EQPW3, sfpe_pkg::OP_EQPW4};
  logic        i_clk = 1'b0;
  logic        i_reset = 1'b1;
  logic        sel_n, sclk, four, hit, busy, latch, arr_wr, arr_clr;
  logic [3:0]  io;
  logic [7:0]  arr_data;
  logic [31:0] arr_addr, sc_addr, base, qaddr;
  logic [7:0]  mem [logic [31:0]];
  int          failures = 0, checks = 0, nwr = 0, nsc = 0, busy_cnt = 0, len, n0;

  always #5 i_clk = ~i_clk;

  sfpe_core #(.PP_CYCLES(PP), .SC_CYCLES(SC)) u_sfpe_core (
    .i_clk(i_clk), .i_reset(i_reset), .i_sel_n(sel_n), .i_sclk(sclk), .i_quad_io_lines(io),
    .i_four_byte_mode(four), .i_protect_level_bits({5{hit}}), .i_protect_hit(hit), .o_query_addr(qaddr),
    .o_busy_flag(busy), .o_write_latch_flag(latch), .o_array_wr(arr_wr), .o_array_addr(arr_addr),
    .o_array_data(arr_data), .o_array_sector_clear(arr_clr));
  sfpe_host u_sfpe_host (.i_clk(i_clk), .o_sel_n(sel_n), .o_sclk(sclk), .o_io(io));

  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge i_clk)
  begin
    if (arr_wr === 1'b1)
    begin
      mem[arr_addr] = arr_data;
      nwr++;
    end
    if (arr_clr === 1'b1)
    begin
      sc_addr = arr_addr;
      nsc++;
    end
    if (busy === 1'b1)
      busy_cnt++;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Busy may already be up when the frame returns, so the monitor counts it.
  task automatic run(input logic [7:0] op, input logic [31:0] addr, input int nab, input int nd,
                     input bit quad, input int extra);
    busy_cnt = 0;
    u_sfpe_host.frame(op, addr, nab, nd, 8'(op), quad, extra);
    u_sfpe_host.step(10);
    for (int w = 0; w < SC + 50 && busy === 1'b1; w++)
      u_sfpe_host.step(1);
    len = busy_cnt;
  endtask

  task automatic unlock();
    u_sfpe_host.frame(sfpe_pkg::OP_UNLOCK, 32'h0, 0, 0, 8'h00, 1'b0, 0);
    check(latch, 1'b1);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    #600000;
    failures++;
    conclude();
  end

  initial
  begin
    four = 1'b0;
    hit  = 1'b0;
    u_sfpe_host.step(20);
    i_reset = 1'b0;
    u_sfpe_host.step(4);
    check({busy, latch, arr_wr, arr_clr}, 4'h0);
    run(sfpe_pkg::OP_PW3, 32'h100, 3, 4, 1'b0, 0);
    check(len, 0);
    check(nwr, 0);
    $display("test no_unlock done");
    for (int i = 0; i < 6; i++)
    begin
      four = i[0];
      base = (four ? 32'h0100_0000 : 32'h0) + 32'((i + 1) * 256);
      unlock();
      n0 = nwr;
      run(PROG_OPS[i], base | 32'hF0, four ? 4 : 3, 20, i >= 2, 0);
      check(32'(len >= PP && len <= PP + 1), 1);
      check(latch, 1'b0);
      check(nwr - n0, 20);
      check(32'(mem.exists(base | 32'h10)), 0);
      for (int k = 0; k < 20; k++)
        check(mem[base | 32'((240 + k) % 256)], u_sfpe_host.dat(k, PROG_OPS[i]));
    end
    $display("test program_wrap done");
    four = 1'b0;
    unlock();
    n0 = nwr;
    run(sfpe_pkg::OP_QPW3, 32'h3000, 3, 260, 1'b1, 0);
    check(nwr - n0, 256);
    check({mem[32'h3000], mem[32'h3003], mem[32'h3004], mem[32'h30FF]},
          {8'hA5, 8'hA5, u_sfpe_host.dat(4, 8'h32), u_sfpe_host.dat(255, 8'h32)});
    $display("test overflow done");
    unlock();
    n0 = nwr + nsc;
    run(sfpe_pkg::OP_PW3, 32'h4000, 3, 2, 1'b0, 3);
    check(len, 0);
    run(sfpe_pkg::OP_SC3, 32'h4000, 4, 0, 1'b0, 0);
    check(len, 0);
    hit = 1'b1;
    run(sfpe_pkg::OP_SC3, 32'h4000, 3, 0, 1'b0, 0);
    check(len, 0);
    run(sfpe_pkg::OP_PW3, 32'h4000, 3, 2, 1'b0, 0);
    check(len, 0);
    check(nwr + nsc - n0, 0);
    hit = 1'b0;
    $display("test refusals done");
    for (int j = 0; j < 2; j++)
    begin
      four = j[0];
      unlock();
      n0 = nsc;
      run(four ? sfpe_pkg::OP_SC4 : sfpe_pkg::OP_SC3, four ? 32'h0201_2345 : 32'h0001_2345, 3 + j, 0, 1'b0, 0);
      check(32'(len >= SC && len <= SC + 1), 1);
      check(nsc - n0, 1);
      check(sc_addr, four ? 32'h0201_2000 : 32'h0001_2000);
      check(qaddr, four ? 32'h0201_2345 : 32'h0001_2345);
      check(latch, 1'b0);
    end
    $display("test sector_clear done");
    conclude();
  end
endmodule
